// *** common/i2cmas_pkg.sv ***
/*
  i2cmas_pkg: register offsets, bit positions, reset values and states
  for the i2c master sequencer.
  assumes a classic wishbone slave with 32-bit data, word aligned.
*/
package i2cmas_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0; // master_control_two
  localparam logic [3:0] ADDR_STAT = 4'h4; // port_status and flags
  localparam logic [3:0] ADDR_BUF = 4'h8; // transfer_buffer
  localparam logic [3:0] ADDR_BAUD = 4'hc; // baud_reload_register
  // control register bits
  localparam int CTRL_START = 0;
  localparam int CTRL_RSTART = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_ACK = 3;
  localparam int CTRL_ACK_DATA_VALUE = 4;
  localparam int CTRL_PORT_EN = 5;
  localparam int CTRL_SLEEP = 6;
  localparam int CTRL_IRQ_EN = 7;
  // status register bits
  localparam int STAT_BUF_FULL = 0;
  localparam int STAT_START_SEEN = 1;
  localparam int STAT_STOP_SEEN = 2;
  localparam int STAT_WRITE_COLLISION_FLAG = 3;
  localparam int STAT_BCOL = 4;
  localparam int STAT_PIF = 5;
  localparam int STAT_ACKSTAT = 6;
  localparam int STAT_BUSY = 7;
  // reset values
  localparam logic [7:0] BAUD_RESET = 8'h09;
  localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;
  // bits per byte on the wire
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // instruction-rate clock is the system clock divided by four
  localparam int CY_DIV = 4;

  typedef enum logic [4:0] {
    ST_IDLE,
    ST_ACK_LOW, ST_ACK_HIGH, ST_ACK_END,
    ST_STOP_SDA, ST_STOP_CNT, ST_STOP_SCL, ST_STOP_REL, ST_STOP_DONE,
    ST_START_CHK, ST_START_CNT, ST_START_HOLD,
    ST_RS_SDA, ST_RS_SCL, ST_RS_CHK, ST_RS_CNT, ST_RS_HOLD,
    ST_TX_LOW, ST_TX_HIGH, ST_TX_ACK_LOW, ST_TX_ACK_HIGH
  } i2cmas_state_t;
endpackage

// *** tb/i2cmas_bus_model.sv ***
/*
  i2cmas_bus_model: the rest of the i2c bus, other masters and slaves.
  assumes pull-ups on both lines; the bench commands stretch and holds.
*/
`timescale 1ns/10ps
module i2cmas_bus_model (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  input wire logic scl_oe_i,
  input wire logic hold_sda_i,
  input wire logic hold_scl_i,
  input wire logic [7:0] stretch_i,
  output logic sda_o,
  output logic scl_o
);
  logic [7:0] stretch_q = 8'h00;
  // a slow slave keeps scl low a while after the master lets go
  always_ff @(posedge clk_i) begin
    if (scl_oe_i) begin
      stretch_q <= stretch_i;
    end else if (stretch_q != 8'h00) begin
      stretch_q <= stretch_q - 8'h01;
    end
  end
  // wired-and with pull-ups: a released line reads high, never stale
  assign scl_o = !(scl_oe_i || hold_scl_i || stretch_q != 8'h00);
  assign sda_o = !(sda_oe_i || hold_sda_i);
endmodule

// *** tb/i2cmas_top_properties.sv ***
/*
  i2cmas_chk: port-level checker for the i2c master sequencer.
  assumes one clock, synchronous active-high reset; bound below.
*/
`timescale 1ns/10ps
module i2cmas_chk
  import i2cmas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic wake_o
);
  logic wr_ctrl;
  logic ack_data_value_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a control write lands at the edge that samples ack
  assign wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL;
  // keep the acknowledge level software asked for
  always_ff @(posedge clk_i) begin
    if (wr_ctrl) begin
      ack_data_value_q <= wb_dat_i[CTRL_ACK_DATA_VALUE];
    end
  end
  // bus handshake
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered one cycle later");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // open-drain: the pins only ever pull low
  a_pins_low_only: assert property (!sda_o && !scl_o)
    else $error("pin output level not low");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> !sda_oe_o && !scl_oe_o && !wb_ack_o && !wake_o)
    else $error("outputs active right after reset");
  a_ack_drive: assert property (
    wr_ctrl && wb_dat_i[3:0] == 4'h8 && wb_dat_i[CTRL_PORT_EN]
    |-> ##[1:6] (scl_oe_o && sda_oe_o == !ack_data_value_q))
    else $error("ack sequence did not drive scl and ack level");
  // a half period is at least thirteen cycles for any legal reload
  a_scl_high_min: assert property ($fell(scl_oe_o) |=> !scl_oe_o [*8])
    else $error("scl released for too short a time");
  a_scl_low_min: assert property ($rose(scl_oe_o) |=> scl_oe_o [*8])
    else $error("scl held low for too short a time");
  a_wake_clear: assert property (
    wr_ctrl && !wb_dat_i[CTRL_SLEEP] |=> ##[0:2] !wake_o)
    else $error("wake stays up after leaving sleep");
  c_ack_seq: cover property (wr_ctrl && wb_dat_i[CTRL_ACK]);
  c_scl_release: cover property ($fell(scl_oe_o));
  c_stop_edge: cover property ($fell(sda_oe_o) && !scl_oe_o);
endmodule

bind i2cmas_top i2cmas_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sda_i,
  .sda_o, .sda_oe_o, .scl_i, .scl_o, .scl_oe_o, .wake_o);

// *** tb/tb.sv ***
/*
  tb: register-level tests of the i2c master sequencer.
  assumes the bus model on the pins and wishbone access to registers.
*/
`timescale 1ns/10ps
module tb;
  import i2cmas_pkg::*;
  localparam logic [7:0] RLD = 8'h03;
  localparam int HP = (RLD + 1) * CY_DIV;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, sda, scl, sda_oe_o, scl_oe_o, wake_o;
  logic hold_sda = 1'b0;
  logic hold_scl = 1'b0;
  logic [7:0] stretch = 8'h05;
  logic [7:0] rd;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;

  always #5 clk_i = ~clk_i;

  i2cmas_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o), .wake_o(wake_o));
  i2cmas_bus_model u_bus (.clk_i(clk_i), .sda_oe_i(sda_oe_o),
    .scl_oe_i(scl_oe_o), .hold_sda_i(hold_sda), .hold_scl_i(hold_scl),
    .stretch_i(stretch), .sda_o(sda), .scl_o(scl));

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle, held until ack; read data taken at that edge
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
          input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, rd & m, e);
  endtask

  task wpoll(input logic [3:0] a, input int b, input logic v);
    do wb(1'b0, a, 8'h00); while (rd[b] !== v);
  endtask

  // wait for a pin enable level, counting cycles in n
  task wpin(input bit s, input logic v);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((s ? sda_oe_o : scl_oe_o) !== v);
  endtask

  // hang guard, well above the roughly one thousand cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      wrap_up;
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(ADDR_BAUD, 8'hff, BAUD_RESET, "baud reset");
    rc(ADDR_CTRL, 8'hff, 8'h00, "ctrl reset");
    rc(ADDR_STAT, 8'hff, 8'h00, "stat reset");
    rc(4'h2, 8'hff, 8'h00, "unmapped");
    wb(1'b1, ADDR_BAUD, RLD);
    rc(ADDR_BAUD, 8'hff, RLD, "baud write");
    // ack then not-ack; slave stretches, a buffer write must bounce
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, ADDR_CTRL, {3'h1, i[0], 4'h0});
      wb(1'b1, ADDR_CTRL, {3'h1, i[0], 4'h8});
      wb(1'b1, ADDR_BUF, 8'h55);
      wpin(1'b0, 1'b0);
      chk("ack level", {7'h00, sda_oe_o}, {7'h00, !i[0]});
      wpin(1'b0, 1'b1);
      chk("ack high", {7'h00, n >= HP + 2 && n <= HP + 20}, 8'h01);
      rc(ADDR_CTRL, 8'h08, 8'h00, "ack done");
      chk("scl parked", {7'h00, scl_oe_o}, 8'h01);
      rc(ADDR_STAT, 8'h09, 8'h08, "write_collision_flag ack");
      wb(1'b1, ADDR_STAT, 8'h28); // clear write_collision_flag and pif for the stop check
    end
    // stop: sda low, scl freed, sda freed a half period later
    stretch <= 8'h00;
    wb(1'b1, ADDR_CTRL, 8'h34);
    wb(1'b1, ADDR_BUF, 8'h55);
    wpin(1'b1, 1'b1);
    chk("stop scl held", {7'h00, scl_oe_o}, 8'h01);
    wpin(1'b0, 1'b0);
    chk("stop sda held", {7'h00, sda_oe_o}, 8'h01);
    wpin(1'b1, 1'b0);
    chk("stop gap", {7'h00, n > HP - 4}, 8'h01);
    wpoll(ADDR_CTRL, CTRL_STOP, 1'b0);
    rc(ADDR_STAT, 8'h2c, 8'h2c, "stop flags");
    wb(1'b1, ADDR_CTRL, 8'h00);
    rc(ADDR_STAT, 8'h06, 8'h00, "seen cleared");
    // start while another master already holds sda low
    hold_sda <= 1'b1;
    wb(1'b1, ADDR_STAT, 8'h38);
    wb(1'b1, ADDR_CTRL, 8'h21);
    wpoll(ADDR_CTRL, CTRL_START, 1'b0);
    rc(ADDR_STAT, 8'h10, 8'h10, "start bcol");
    chk("start free", {6'h00, sda_oe_o, scl_oe_o}, 8'h00);
    hold_sda <= 1'b0;
    wb(1'b1, ADDR_STAT, 8'h38);
    wb(1'b1, ADDR_CTRL, 8'h21);
    wpoll(ADDR_CTRL, CTRL_START, 1'b0);
    chk("start done", {6'h00, sda_oe_o, scl_oe_o}, 8'h03);
    // all-ones byte lost to a master sending zeros
    hold_sda <= 1'b1;
    wb(1'b1, ADDR_STAT, 8'h20);
    wb(1'b1, ADDR_BUF, 8'hff);
    rc(ADDR_STAT, 8'h01, 8'h01, "buf full");
    wpoll(ADDR_STAT, STAT_BCOL, 1'b1);
    rc(ADDR_STAT, 8'h01, 8'h00, "bcol bf");
    chk("tx free", {6'h00, sda_oe_o, scl_oe_o}, 8'h00);
    wb(1'b1, ADDR_STAT, 8'h38);
    hold_sda <= 1'b0;
    wpoll(ADDR_STAT, STAT_PIF, 1'b1);
    rc(ADDR_STAT, 8'h04, 8'h04, "bus stop");
    // a new byte starts from its first bit, here a zero
    wb(1'b1, ADDR_STAT, 8'h38);
    wb(1'b1, ADDR_BUF, 8'h7f);
    wpin(1'b0, 1'b1);
    wpin(1'b0, 1'b0);
    chk("first bit", {7'h00, sda_oe_o}, 8'h01);
    wpoll(ADDR_STAT, STAT_BUSY, 1'b0);
    // repeated start: scl pulled low before sda is driven
    wb(1'b1, ADDR_CTRL, 8'h22);
    wpin(1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    hold_scl <= 1'b1;
    wpoll(ADDR_CTRL, CTRL_RSTART, 1'b0);
    rc(ADDR_STAT, 8'h10, 8'h10, "rs bcol");
    chk("rs free", {6'h00, sda_oe_o, scl_oe_o}, 8'h00);
    hold_scl <= 1'b0;
    // another master sends 0x55 to us while asleep: a whole byte wakes
    wb(1'b1, ADDR_CTRL, 8'he0);
    hold_sda <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int b = 0; b < 8; b++) begin
      hold_scl <= 1'b1;
      repeat (8) @(posedge clk_i);
      hold_sda <= !b[0];
      repeat (8) @(posedge clk_i);
      hold_scl <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    chk("wake", {7'h00, wake_o}, 8'h01);
    rc(ADDR_BUF, 8'hff, 8'h55, "rx byte");
    wb(1'b1, ADDR_CTRL, 8'h20);
    repeat (2) @(negedge clk_i);
    chk("wake off", {7'h00, wake_o}, 8'h00);
    // reset in the middle of an ack sequence
    wb(1'b1, ADDR_STAT, 8'h38);
    wb(1'b1, ADDR_CTRL, 8'h28);
    wpin(1'b0, 1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset pins", {5'h00, wake_o, sda_oe_o, scl_oe_o}, 8'h00);
    rc(ADDR_CTRL, 8'hff, 8'h00, "reset ctrl");
    rc(ADDR_STAT, 8'h06, 8'h00, "reset seen");
    wrap_up;
  end
endmodule

// *** verilog/i2cmas_top.sv ***
/*
  i2cmas_top: i2c master sequences (acknowledge, stop, start, repeated
  start, byte transmit) with multi-master arbitration, plus a minimal
  slave byte watcher (no address compare) for sleep wake.
  assumes sda/scl are open-drain pins resolved outside; one 100 mhz clock.
*/
// Chosen here: register access over Wishbone and the address map.
// What this block does
// RULE1: setting ack enable pulls scl low and drives ack data onto sda.
// RULE2: software picks ack data value before starting the ack sequence.
// RULE3: ack waits half period, releases scl, waits high half period, pulls low.
// RULE4: after final scl low, ack enable clears itself, counter stops, idle.
// RULE5: buffer writes during ack or stop are dropped and set write collision.
// RULE6: stop enable drives sda low; once sampled low, counter reloads and runs.
// RULE7: at stop count expiry scl releases; sda releases one half period later.
// RULE8: sda high with scl high sets stop seen; half period later flag, clear.
// RULE9: while asleep the slave watcher wakes on address match or full byte; here only a full byte wakes, with no address compare.
// RULE10: reset disables the port and aborts any transfer.
// RULE11: start and stop seen clear on reset and while the port is disabled.
// RULE12: released one but sda sampled low with scl high gives collision.
// RULE13: collision in a byte halts it, clears buffer full, frees lines.
// RULE14: collision in a sequence aborts it, frees lines, clears its enable.
// RULE15: after collision the bus is watched; a stop sets port interrupt.
// RULE16: a buffer write after collision starts again at the first bit.
// RULE17: start requested with sda or scl low aborts with a collision.
// RULE18: start counts once sda is high; scl low while sda high collides.
// RULE19: sda falling early restarts count; then hold count drives scl low.
// RULE20: repeated start frees sda, counts, frees scl; sda low then collides.
// RULE21: sda fall before expiry is fine; scl fall before sda low collides.
// RULE22: both high at expiry drives sda low, reloads, then scl low.
// RULE23: counter reloads from baud register; bus clock is fcy over reload+1; here a half period is reload+1 cycles, so fcy over 2*(reload+1).
// RULE24: software never programs baud reload values zero, one or two.
// RULE25: a half period is one countdown from reload to zero at cycle rate.
`timescale 1ns/10ps
module i2cmas_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic wake_o
);
  import i2cmas_pkg::*;

  // pin synchronisers: stage one is read only by stage two
  logic [1:0] sda_sync_q, scl_sync_q;
  logic sda_prev_q, scl_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
      sda_prev_q <= 1'b1;
      scl_prev_q <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_prev_q <= sda_sync_q[1];
      scl_prev_q <= scl_sync_q[1];
    end
  end
  wire sda_s = sda_sync_q[1];
  wire scl_s = scl_sync_q[1];
  wire start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  wire stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // register state
  logic start_en_q, rstart_en_q, stop_en_q, ack_en_q, ack_data_value_q;
  logic port_en_q, sleep_q, irq_en_q;
  logic buf_full_q, write_collision_flag_q, bcol_q, pif_q, ackstat_q;
  logic start_seen_q, stop_seen_q;
  logic [7:0] buf_q, baud_q, shift_q;
  logic [3:0] bitcnt_q;
  i2cmas_state_t state_q;
  logic [7:0] rx_shift_q;
  logic [3:0] rx_cnt_q;
  logic rx_active_q, rx_done, wake_ev;

  // bus decode: single-cycle answer, ack drops the cycle after
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a write lands at the edge where the master samples ack high
  wire wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire wr_ctrl = wb_wr && wb_adr_i == ADDR_CTRL;
  wire wr_stat = wb_wr && wb_adr_i == ADDR_STAT;
  wire wr_buf = wb_wr && wb_adr_i == ADDR_BUF;
  wire wr_baud = wb_wr && wb_adr_i == ADDR_BAUD;
  wire rd_buf = wb_req && !wb_we_i && wb_adr_i == ADDR_BUF;
  wire idle = state_q == ST_IDLE;
  // transmit accepted only when idle and no sequence is pending
  wire seq_busy = ack_en_q || stop_en_q || start_en_q || rstart_en_q;
  wire buf_take = wr_buf && port_en_q && idle && !seq_busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          ADDR_CTRL: wb_dat_o[7:0] <= {irq_en_q, sleep_q, port_en_q,
            ack_data_value_q, ack_en_q, stop_en_q, rstart_en_q, start_en_q};
          ADDR_STAT: wb_dat_o[7:0] <= {!idle, ackstat_q, pif_q, bcol_q,
            write_collision_flag_q, stop_seen_q, start_seen_q, buf_full_q};
          ADDR_BUF: wb_dat_o[7:0] <= buf_q;
          ADDR_BAUD: wb_dat_o[7:0] <= baud_q;
          default: wb_dat_o <= 32'h0; // unmapped reads as zero
        endcase
      end
    end
  end

  // instruction-rate enable and baud rate counter
  logic [1:0] cy_q;
  logic [7:0] brg_q;
  logic brg_run_q, brg_load;
  wire cy_tick = cy_q == 2'(CY_DIV - 1);
  wire brg_done = brg_run_q && cy_tick && brg_q == 8'h0; // RULE25
  always_ff @(posedge clk_i) begin
    if (rst_i) cy_q <= 2'h0;
    else cy_q <= cy_q + 2'h1;
  end
  // reload from the baud register; one countdown is one half period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brg_q <= 8'h0;
    end else if (brg_load) begin
      brg_q <= baud_q; // RULE23
    end else if (brg_run_q && cy_tick && brg_q != 8'h0) begin
      brg_q <= brg_q - 8'h1;
    end else if (brg_done) begin
      brg_q <= baud_q; // free reload so each half period is equal
    end
  end

  // level of the current transmit bit; the ninth bit is always released
  logic tx_bit_low;
  always_comb tx_bit_low = bitcnt_q != BITS_PER_BYTE && !shift_q[7];

  // main sequencer: next state, line drive, counter control, events
  i2cmas_state_t st_d;
  logic sda_low_d, scl_low_d, run_d, col_ev, done_ev, stop_p_ev;
  logic clr_start, clr_rs, clr_stop, clr_ack, tx_end, shift_ev;
  logic sda_low_q, scl_low_q;
  always_comb begin
    st_d = state_q;
    sda_low_d = sda_low_q;
    scl_low_d = scl_low_q;
    run_d = brg_run_q;
    brg_load = 1'b0;
    col_ev = 1'b0;
    done_ev = 1'b0;
    stop_p_ev = 1'b0;
    clr_start = 1'b0;
    clr_rs = 1'b0;
    clr_stop = 1'b0;
    clr_ack = 1'b0;
    tx_end = 1'b0;
    shift_ev = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        run_d = 1'b0;
        if (port_en_q && start_en_q) begin
          if (!sda_s || !scl_s) begin
            col_ev = 1'b1; // RULE17
            clr_start = 1'b1;
          end else begin
            brg_load = 1'b1; // RULE18
            run_d = 1'b1;
            st_d = ST_START_CNT;
          end
        end else if (port_en_q && rstart_en_q) begin
          sda_low_d = 1'b0; // RULE20
          brg_load = 1'b1;
          run_d = 1'b1;
          st_d = ST_RS_SDA;
        end else if (port_en_q && stop_en_q) begin
          sda_low_d = 1'b1; // RULE6
          st_d = ST_STOP_SDA;
        end else if (port_en_q && ack_en_q) begin
          scl_low_d = 1'b1; // RULE1
          sda_low_d = !ack_data_value_q;
          brg_load = 1'b1;
          run_d = 1'b1;
          st_d = ST_ACK_LOW;
        end else if (buf_take) begin
          sda_low_d = 1'b0; // bit level comes from the shifter
          brg_load = 1'b1; // RULE16
          run_d = 1'b1;
          scl_low_d = 1'b1;
          st_d = ST_TX_LOW;
        end
      end
      ST_ACK_LOW: if (brg_done) begin
        scl_low_d = 1'b0; // RULE3
        run_d = 1'b0;
        st_d = ST_ACK_HIGH;
      end
      ST_ACK_HIGH: if (scl_s) begin
        brg_load = 1'b1;
        run_d = 1'b1;
        st_d = ST_ACK_END;
      end
      ST_ACK_END: begin
        if (!ack_data_value_q && !sda_s) begin
          // nothing to check: we drive the low ourselves
        end else if (ack_data_value_q && !sda_s) begin
          col_ev = 1'b1; // RULE12 RULE14
        end
        if (brg_done) begin
          scl_low_d = 1'b1; // RULE4
          run_d = 1'b0;
          clr_ack = 1'b1;
          done_ev = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_STOP_SDA: if (!sda_s) begin
        brg_load = 1'b1; // RULE6
        run_d = 1'b1;
        st_d = ST_STOP_CNT;
      end
      ST_STOP_CNT: if (brg_done) begin
        scl_low_d = 1'b0; // RULE7
        st_d = ST_STOP_SCL;
      end
      ST_STOP_SCL: if (brg_done) begin
        sda_low_d = 1'b0; // RULE7
        st_d = ST_STOP_REL;
      end
      ST_STOP_REL: if (sda_s && scl_s) begin
        stop_p_ev = 1'b1; // RULE8
        brg_load = 1'b1;
        st_d = ST_STOP_DONE;
      end
      ST_STOP_DONE: if (brg_done) begin
        clr_stop = 1'b1; // RULE8
        done_ev = 1'b1;
        run_d = 1'b0;
        st_d = ST_IDLE;
      end
      ST_START_CNT: begin
        if (!scl_s && sda_s) begin
          col_ev = 1'b1; // RULE18
        end else if (!sda_s || brg_done) begin
          sda_low_d = 1'b1; // RULE19
          brg_load = 1'b1;
          st_d = ST_START_HOLD;
        end
      end
      ST_START_HOLD: if (brg_done) begin
        scl_low_d = 1'b1; // RULE19
        run_d = 1'b0;
        clr_start = 1'b1;
        done_ev = 1'b1;
        st_d = ST_IDLE;
      end
      ST_RS_SDA: if (brg_done) begin
        scl_low_d = 1'b0; // RULE20
        run_d = 1'b0;
        st_d = ST_RS_SCL;
      end
      ST_RS_SCL: if (scl_s) begin
        if (!sda_s) begin
          col_ev = 1'b1; // RULE20
        end else begin
          brg_load = 1'b1; // RULE21
          run_d = 1'b1;
          st_d = ST_RS_CNT;
        end
      end
      ST_RS_CNT: begin
        if (!scl_s && sda_s) begin
          col_ev = 1'b1; // RULE21
        end else if (brg_done) begin
          sda_low_d = 1'b1; // RULE22
          brg_load = 1'b1;
          st_d = ST_RS_HOLD;
        end
      end
      ST_RS_HOLD: if (brg_done) begin
        scl_low_d = 1'b1; // RULE22
        run_d = 1'b0;
        clr_rs = 1'b1;
        done_ev = 1'b1;
        st_d = ST_IDLE;
      end
      ST_TX_LOW: if (brg_done) begin
        scl_low_d = 1'b0;
        st_d = bitcnt_q == BITS_PER_BYTE ? ST_TX_ACK_HIGH : ST_TX_HIGH;
      end
      ST_TX_HIGH: begin
        if (scl_s && !tx_bit_low && !sda_s) begin
          col_ev = 1'b1; // RULE12 RULE13
        end else if (brg_done) begin
          scl_low_d = 1'b1;
          shift_ev = 1'b1;
          st_d = ST_TX_LOW;
        end
      end
      ST_TX_ACK_HIGH: if (brg_done) begin
        scl_low_d = 1'b1;
        tx_end = 1'b1;
        done_ev = 1'b1;
        run_d = 1'b0;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (col_ev) begin
      sda_low_d = 1'b0; // RULE13 RULE14
      scl_low_d = 1'b0;
      run_d = 1'b0;
      clr_start = 1'b1;
      clr_rs = 1'b1;
      clr_stop = 1'b1;
      clr_ack = 1'b1;
      st_d = ST_IDLE;
    end
    if (!port_en_q) begin
      sda_low_d = 1'b0; // RULE10
      scl_low_d = 1'b0;
      run_d = 1'b0;
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE; // RULE10
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      brg_run_q <= 1'b0;
    end else begin
      state_q <= st_d;
      sda_low_q <= sda_low_d;
      scl_low_q <= scl_low_d;
      brg_run_q <= run_d;
    end
  end

  // open-drain drive: enable only when pulling low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe_o <= st_d == ST_TX_LOW || st_d == ST_TX_HIGH ?
        (sda_low_d || (st_d != ST_IDLE && tx_bit_low)) : sda_low_d;
      scl_oe_o <= scl_low_d;
    end
  end

  // transmit shifter: msb first, bit data changes while scl low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= 8'h0;
      bitcnt_q <= 4'h0;
      ackstat_q <= 1'b0;
    end else if (buf_take) begin
      shift_q <= wb_dat_i[7:0]; // RULE16
      bitcnt_q <= 4'h0;
    end else if (shift_ev) begin
      shift_q <= {shift_q[6:0], 1'b0};
      bitcnt_q <= bitcnt_q + 4'h1;
    end else if (state_q == ST_TX_ACK_HIGH && brg_done) begin
      ackstat_q <= sda_s;
    end
  end

  // software registers; a software write beats a hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_en_q <= 1'b0;
      rstart_en_q <= 1'b0;
      stop_en_q <= 1'b0;
      ack_en_q <= 1'b0;
      ack_data_value_q <= 1'b0;
      port_en_q <= 1'b0; // RULE10
      sleep_q <= 1'b0;
      irq_en_q <= 1'b0;
      baud_q <= BAUD_RESET;
      buf_q <= 8'h0;
    end else begin
      if (wr_ctrl) begin
        start_en_q <= wb_dat_i[CTRL_START];
        rstart_en_q <= wb_dat_i[CTRL_RSTART];
        stop_en_q <= wb_dat_i[CTRL_STOP];
        ack_en_q <= wb_dat_i[CTRL_ACK];
        ack_data_value_q <= wb_dat_i[CTRL_ACK_DATA_VALUE];
        port_en_q <= wb_dat_i[CTRL_PORT_EN];
        sleep_q <= wb_dat_i[CTRL_SLEEP];
        irq_en_q <= wb_dat_i[CTRL_IRQ_EN];
      end else begin
        if (clr_start) start_en_q <= 1'b0; // RULE14
        if (clr_rs) rstart_en_q <= 1'b0;
        if (clr_stop) stop_en_q <= 1'b0;
        if (clr_ack) ack_en_q <= 1'b0; // RULE4
      end
      if (wr_baud) baud_q <= wb_dat_i[7:0];
      if (buf_take) buf_q <= wb_dat_i[7:0]; // RULE5
      else if (rx_done) buf_q <= {rx_shift_q[6:0], sda_s}; // eighth bit too
    end
  end

  // status flags: write_collision_flag, bcol and pif clear by writing one, a new event wins
  wire write_collision_flag_ev = wr_buf && port_en_q && (!idle || seq_busy); // RULE5
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_full_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      bcol_q <= 1'b0;
      pif_q <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else begin
      if (buf_take) buf_full_q <= 1'b1;
      else if (col_ev || tx_end || rd_buf) buf_full_q <= 1'b0; // RULE13
      if (write_collision_flag_ev) write_collision_flag_q <= 1'b1;
      else if (wr_stat && wb_dat_i[STAT_WRITE_COLLISION_FLAG]) write_collision_flag_q <= 1'b0;
      if (col_ev) bcol_q <= 1'b1; // RULE12
      else if (wr_stat && wb_dat_i[STAT_BCOL]) bcol_q <= 1'b0;
      if (done_ev || (idle && stop_cond) || rx_done) pif_q <= 1'b1; // RULE15
      else if (wr_stat && wb_dat_i[STAT_PIF]) pif_q <= 1'b0;
      if (!port_en_q) begin
        start_seen_q <= 1'b0; // RULE11
        stop_seen_q <= 1'b0;
      end else if (start_cond) begin
        start_seen_q <= 1'b1;
        stop_seen_q <= 1'b0;
      end else if (stop_cond || stop_p_ev) begin
        stop_seen_q <= 1'b1; // RULE8
        start_seen_q <= 1'b0;
      end
    end
  end

  // slave receiver for sleep wake: counts scl rises after a start
  wire scl_rise = scl_s && !scl_prev_q;
  always_comb begin
    rx_done = rx_active_q && scl_rise && rx_cnt_q == BITS_PER_BYTE - 4'h1;
    wake_ev = rx_done && irq_en_q && sleep_q; // RULE9
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_q) begin
      rx_shift_q <= 8'h0;
      rx_cnt_q <= 4'h0;
      rx_active_q <= 1'b0;
    end else if (start_cond) begin
      rx_cnt_q <= 4'h0;
      rx_active_q <= idle; // only watch bytes that others drive
    end else if (stop_cond) begin
      rx_active_q <= 1'b0;
    end else if (rx_active_q && scl_rise) begin
      rx_shift_q <= {rx_shift_q[6:0], sda_s};
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) wake_o <= 1'b0;
    else if (wake_ev) wake_o <= 1'b1; // RULE9
    else if (!sleep_q) wake_o <= 1'b0;
  end
endmodule
